// file: logic/epc_ctrl.sv
// Program/erase controller for a 512-byte EEPROM array behind AXI4-Lite.
// Function
// - Manage 512 bytes from 0x0800 in four 128-byte blocks, each protectable.
// - Protect bits 0..3 cover 0x0800, 0x0880, 0x0900, 0x0980 blocks respectively.
// - Target in protected block keeps high voltage off until a config-byte read reloads its protect bit to zero.
// - Config byte copied to volatile config at reset and each read.
// - Erased cells read one; programming only clears bits.
// - Only unprotected array bytes or the config byte may be altered.
// - Nonzero erase-select turns a program sequence into an erase.
// - Latch captures only valid array or config-byte writes; later ones replace earlier while enable is clear.
// - While latched with a write captured, reads of other array locations return captured data.
// - Once latched, control writes ignored until a valid write captured.
// - Program-enable cannot be set without latch and captured write.
// - Program-enable switches pump and high voltage on; clearing removes them.
// - Clearing enable and latch together clears only enable.
// - Block erase clears captured block, bulk whole array, config byte untouched.
// - Any protect bit blocks bulk erase; protected blocks never erased.
// - Erase-select 00 program, 01 byte, 10 block, 11 bulk erase.
// - Reset clears enable, latch and both erase-select bits.
// - Protect bit one protects its block; zero leaves it open.
`timescale 1ns/1ps
`default_nettype none
module epc_ctrl (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic [15:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [15:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic PUMP_EN
);
  // Bus holding registers.
  logic aw_have_q;
  logic w_have_q;
  logic [15:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Control and configuration state.
  logic program_enable_bit_q;
  logic bus_latch_bit_q;
  logic erase_select_hi_q;
  logic erase_select_lo_q;
  logic captured_q;
  logic cap_nv_q;
  logic [8:0] cap_idx_q;
  logic [7:0] cap_data_q;
  logic [7:0] nonvolatile_config_byte_q;
  logic [7:0] volatile_array_config_register_q;

  logic wr_fire;
  logic rd_fire;
  logic wr_array;
  logic wr_nv;
  logic wr_ctrl;
  logic rd_array;
  logic [8:0] wr_idx;
  logic [8:0] rd_idx;
  logic [7:0] cell_rd;
  logic [3:0] block_protect_bit;
  logic [1:0] mode;
  logic op_allowed;
  logic hv_on;
  logic ctrl_pgm_in;
  logic ctrl_lat_in;
  logic wr_mapped;
  logic rd_nv;

  assign S_AXI_AWREADY = !aw_have_q && !bvalid_q;
  assign S_AXI_WREADY = !w_have_q && !bvalid_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;

  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign rd_fire = S_AXI_ARVALID && !rvalid_q;
  assign wr_idx = awaddr_q[10:2];
  assign rd_idx = S_AXI_ARADDR[10:2];
  assign wr_array = (awaddr_q[15:11] == epc_pkg::ARRAY_WIN) && wlane_q;
  assign wr_nv = (awaddr_q == epc_pkg::OFS_NVCFG) && wlane_q;
  assign wr_ctrl = (awaddr_q == epc_pkg::OFS_CTRL) && wlane_q;
  assign rd_array = S_AXI_ARADDR[15:11] == epc_pkg::ARRAY_WIN;
  assign ctrl_pgm_in = wbyte_q[epc_pkg::CTRL_PGM];
  assign ctrl_lat_in = wbyte_q[epc_pkg::CTRL_LAT];
  assign wr_mapped = (awaddr_q[15:11] == epc_pkg::ARRAY_WIN) || (awaddr_q == epc_pkg::OFS_CTRL) ||
                     (awaddr_q == epc_pkg::OFS_NVCFG) || (awaddr_q == epc_pkg::OFS_VCFG) ||
                     (awaddr_q == epc_pkg::OFS_STAT);
  assign rd_nv = rd_fire && (S_AXI_ARADDR[15:2] == epc_pkg::OFS_NVCFG[15:2]);

  // Write address and data are taken in either order and held until both are here.
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      aw_have_q <= 1'b0;
      awaddr_q <= 16'h0000;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_have_q <= 1'b1;
      awaddr_q <= {S_AXI_AWADDR[15:2], 2'b00};
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      w_have_q <= 1'b0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_have_q <= 1'b1;
      wbyte_q <= S_AXI_WDATA[7:0];
      wlane_q <= S_AXI_WSTRB[0];
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  // Unmapped addresses answer SLVERR; a write without lane 0 changes nothing.
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      bvalid_q <= 1'b0;
      bresp_q <= epc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      if (wr_mapped) begin
        bresp_q <= epc_pkg::RESP_OKAY;
      end else begin
        bresp_q <= epc_pkg::RESP_SLVERR;
      end
    end else if (S_AXI_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  // Protection and mode decode of the captured target.
  // The config byte has no protect bit of its own, so only block and bulk erase exclude it.
  assign block_protect_bit = volatile_array_config_register_q[3:0];
  assign mode = {erase_select_hi_q, erase_select_lo_q};

  always_comb begin
    op_allowed = 1'b0;
    unique case (epc_pkg::epc_mode_t'(mode))
      epc_pkg::EPC_BYTE_PGM, epc_pkg::EPC_BYTE_ERASE: begin
        op_allowed = cap_nv_q || !block_protect_bit[cap_idx_q[8:7]];
      end
      epc_pkg::EPC_BLOCK_ERASE: begin
        op_allowed = !cap_nv_q && !block_protect_bit[cap_idx_q[8:7]];
      end
      epc_pkg::EPC_BULK_ERASE: begin
        op_allowed = !cap_nv_q && !(|block_protect_bit);
      end
    endcase
  end

  // Voltage follows the enable bit with no timer behind it.
  // Software owns every program and erase time; a stuck enable keeps the pump running.
  assign hv_on = program_enable_bit_q && bus_latch_bit_q && captured_q &&
                 op_allowed;
  assign PUMP_EN = hv_on;

  // Control register.
  // A write that arrives latched but before any capture is dropped whole, enable bit included.
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      program_enable_bit_q <= 1'b0;
      bus_latch_bit_q <= 1'b0;
      erase_select_hi_q <= 1'b0;
      erase_select_lo_q <= 1'b0;
    end else if (wr_fire && wr_ctrl && !(bus_latch_bit_q && !captured_q)) begin
      // Enable may rise only with the latch already set and a write captured.
      program_enable_bit_q <= ctrl_pgm_in &&
                              (program_enable_bit_q || (bus_latch_bit_q && captured_q));
      // The latch cannot drop while the pump may still be discharging.
      bus_latch_bit_q <= ctrl_lat_in || program_enable_bit_q;
      if (!program_enable_bit_q) begin
        erase_select_hi_q <= wbyte_q[epc_pkg::CTRL_ERHI];
        erase_select_lo_q <= wbyte_q[epc_pkg::CTRL_ERLO];
      end
    end
  end

  // Captured target; frozen while enable is set so the operation cannot move.
  // A write without lane 0 is never a target, so it cannot arm the pump.
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      captured_q <= 1'b0;
      cap_nv_q <= 1'b0;
      cap_idx_q <= 9'h000;
      cap_data_q <= 8'h00;
    end else if (!bus_latch_bit_q) begin
      captured_q <= 1'b0;
    end else if (wr_fire && (wr_array || wr_nv) && !program_enable_bit_q) begin
      captured_q <= 1'b1;
      cap_nv_q <= wr_nv;
      cap_idx_q <= wr_array ? wr_idx : 9'h000;
      cap_data_q <= wbyte_q;
    end
  end

  // Config byte: only the high-voltage operation alters it, never block or bulk erase.
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      nonvolatile_config_byte_q <= epc_pkg::NVCFG_RESET;
    end else if (hv_on && cap_nv_q) begin
      if (mode == epc_pkg::EPC_BYTE_PGM) begin
        nonvolatile_config_byte_q <= nonvolatile_config_byte_q & cap_data_q;
      end else begin
        nonvolatile_config_byte_q <= epc_pkg::CELL_ERASED;
      end
    end
  end

  // Reload on every read of the config byte.
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      volatile_array_config_register_q <= epc_pkg::NVCFG_RESET;
    end else if (rd_nv) begin
      volatile_array_config_register_q <= nonvolatile_config_byte_q;
    end
  end

  epc_cells u_cells (
    .clk(CLK_SYS),
    .rst_n(RESETN),
    .rd_idx(rd_idx),
    .rd_data(cell_rd),
    .op_en(hv_on && !cap_nv_q),
    .op_mode(mode),
    .op_idx(cap_idx_q),
    .op_data(cap_data_q)
  );

  // Read channel, one cycle after the address is taken.
  // A read of the config byte returns the stored value while the volatile copy reloads.
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= epc_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= epc_pkg::RESP_OKAY;
      rdata_q <= 32'h00000000;
      if (rd_array) begin
        if (bus_latch_bit_q && captured_q && (cap_nv_q || (cap_idx_q != rd_idx))) begin
          rdata_q[7:0] <= cap_data_q;
        end else begin
          rdata_q[7:0] <= cell_rd;
        end
      end else begin
        unique case (S_AXI_ARADDR[15:2])
          epc_pkg::OFS_CTRL[15:2]: begin
            rdata_q[epc_pkg::CTRL_PGM] <= program_enable_bit_q;
            rdata_q[epc_pkg::CTRL_LAT] <= bus_latch_bit_q;
            rdata_q[epc_pkg::CTRL_ERLO] <= erase_select_lo_q;
            rdata_q[epc_pkg::CTRL_ERHI] <= erase_select_hi_q;
          end
          epc_pkg::OFS_NVCFG[15:2]: begin
            rdata_q[7:0] <= nonvolatile_config_byte_q;
          end
          epc_pkg::OFS_VCFG[15:2]: begin
            rdata_q[7:0] <= volatile_array_config_register_q;
          end
          epc_pkg::OFS_STAT[15:2]: begin
            rdata_q[epc_pkg::STAT_HV] <= hv_on;
            rdata_q[epc_pkg::STAT_CAP] <= captured_q;
            rdata_q[epc_pkg::STAT_NVT] <= cap_nv_q;
            rdata_q[epc_pkg::STAT_IDX +: 9] <= cap_idx_q;
          end
          default: begin
            rresp_q <= epc_pkg::RESP_SLVERR;
          end
        endcase
      end
    end else if (S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule // epc_ctrl
`default_nettype wire

// file: logic/epc_pkg.sv
// Package of constants and the byte-cell array of the program/erase controller.
`timescale 1ns/1ps
`default_nettype none
package epc_pkg;
  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [15:0] OFS_CTRL = 16'h0000;
  localparam logic [15:0] OFS_NVCFG = 16'h0004;
  localparam logic [15:0] OFS_VCFG = 16'h0008;
  localparam logic [15:0] OFS_STAT = 16'h000c;
  // Array window: cell k sits at 0x2000 + 4*k.
  localparam logic [4:0] ARRAY_WIN = 5'h04;
  localparam int ARRAY_BYTES = 512;
  localparam int BLOCK_BYTES = 128;
  // Array address as the device numbers it.
  localparam logic [15:0] ARRAY_ORIGIN = 16'h0800;
  // Control register fields.
  localparam int CTRL_PGM = 0;
  localparam int CTRL_LAT = 2;
  localparam int CTRL_ERLO = 4;
  localparam int CTRL_ERHI = 5;
  // Status register fields.
  localparam int STAT_HV = 0;
  localparam int STAT_CAP = 1;
  localparam int STAT_NVT = 2;
  localparam int STAT_IDX = 16;
  // Config byte: block protect in [3:0].
  localparam logic [7:0] NVCFG_RESET = 8'h10;
  localparam logic [7:0] CELL_ERASED = 8'hff;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    EPC_BYTE_PGM = 2'b00,
    EPC_BYTE_ERASE = 2'b01,
    EPC_BLOCK_ERASE = 2'b10,
    EPC_BULK_ERASE = 2'b11
  } epc_mode_t;
endpackage

module epc_cells (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [8:0] rd_idx,
  output logic [7:0] rd_data,
  input wire logic op_en,
  input wire logic [1:0] op_mode,
  input wire logic [8:0] op_idx,
  input wire logic [7:0] op_data
);
  logic [7:0] cell_q [epc_pkg::ARRAY_BYTES];
  logic [7:0] cell_d [epc_pkg::ARRAY_BYTES];

  assign rd_data = cell_q[rd_idx];

  genvar gi;
  generate
    for (gi = 0; gi < epc_pkg::ARRAY_BYTES; gi++) begin : g_cell
      localparam logic [8:0] IDX = 9'(gi);
      logic hit;
      assign hit = (op_mode == epc_pkg::EPC_BULK_ERASE) ||
                   ((op_mode == epc_pkg::EPC_BLOCK_ERASE) && (op_idx[8:7] == IDX[8:7])) ||
                   (op_idx == IDX);
      assign cell_d[gi] = !(op_en && hit) ? cell_q[gi] :
                          (op_mode == epc_pkg::EPC_BYTE_PGM) ? (cell_q[gi] & op_data) :
                          epc_pkg::CELL_ERASED;
    end
  endgenerate

  // Reset stands in for the factory erased state of the cells.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cell_q <= '{default: epc_pkg::CELL_ERASED};
    end else begin
      cell_q <= cell_d;
    end
  end
endmodule // epc_cells
`default_nettype wire

// file: bench/epc_ctrl_checker.sv
// Bus handshake and pump checker bound to the program/erase controller.
`timescale 1ns/1ps
`default_nettype none
module epc_checker (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic PUMP_EN
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  sequence s_wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_wr_done;
    $rose(S_AXI_BVALID);
  endsequence
  property p_aw_block; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
  a_aw_block: assert property (p_aw_block) else $error("write accepted during response");
  property p_ar_block; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read accepted during response");
  property p_b_after; s_wr_taken |-> ##2 S_AXI_BVALID; endproperty
  a_b_after: assert property (p_b_after) else $error("write response late");
  property p_r_after; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
  a_r_after: assert property (p_r_after) else $error("read response late");
  property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");
  property p_pump_on; $rose(PUMP_EN) |-> s_wr_done; endproperty
  a_pump_on: assert property (p_pump_on) else $error("pump started without write");
  property p_pump_off; $fell(PUMP_EN) |-> $rose(S_AXI_BVALID) || $rose(S_AXI_RVALID); endproperty
  a_pump_off: assert property (p_pump_off) else $error("pump stopped by itself");
endmodule // epc_checker

bind epc_ctrl epc_checker u_chk (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .PUMP_EN(PUMP_EN));
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench for the program/erase controller.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [15:0] ARR = 16'h2000;
  logic clk, rst_n, awv, wv, bready, arv, rready, pump, awr, wrdy, bv, ardy, rv;
  logic [15:0] awa, ara;
  logic [31:0] wd, rdat, d;
  logic [1:0] bresp, rresp, r;
  logic [3:0] ws;
  int num_errors = 0;
  int compares = 0;
  epc_ctrl dut (.CLK_SYS(clk), .RESETN(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(ardy), .S_AXI_RDATA(rdat),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready), .PUMP_EN(pump));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function logic [15:0] ca(input int k);
    return ARR + 16'(4 * k);
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Each transfer starts one edge late so no strobe is assigned twice in one step.
  // The wait for each answer is bounded only by the watchdog.
  task wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    awa <= a;
    wd <= {24'h0, v};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (!bv);
    r = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [15:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && ardy) arv <= 1'b0;
    end while (!rv);
    d = rdat;
    r = rresp;
    rready <= 1'b0;
  endtask
  task rc(input logic [15:0] a, input logic [7:0] e);
    rd(a);
    chk(d, {24'h0, e});
  endtask
  // One full latch, capture, enable, disable, unlatch sequence; a decoy capture is replaced first.
  task op(input logic [1:0] m, input logic [15:0] a, input logic [7:0] v, input logic p);
    logic nv;
    nv = (a == 16'h0004);
    wr(16'h0, {2'b00, m, 4'h4});
    wr(ca(6), ~v);
    wr(a, v);
    rc(ca(7), v);
    wr(16'h0, {2'b00, m, 4'h5});
    wr(16'h0, {2'b00, ~m, 4'h5});
    rc(16'h0, {2'b00, m, 4'h5});
    rd(16'h000c);
    chk(d, {7'h00, (nv ? 9'h000 : a[10:2]), 13'h0000, nv, 1'b1, p});
    @(negedge clk);
    chk(pump, p);
    wr(16'h0, 8'h00);
    rc(16'h0, {2'b00, m, 4'h4});
    chk(pump, 1'b0);
    wr(16'h0, 8'h00);
  endtask
  task give_verdict();
    $display("compares %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    {awv, wv, bready, arv, rready} = '0;
    {awa, ara, wd} = '0;
    ws = 4'h1;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rc(16'h0, 8'h00);
    rc(16'h0008, 8'h10);
    rc(ca(511), 8'hff);
    wr(16'h0, 8'h01);
    rc(16'h0, 8'h00);
    ws <= 4'h0;
    wr(16'h0, 8'h04);
    chk(r, epc_pkg::RESP_OKAY);
    rc(16'h0, 8'h00);
    ws <= 4'h1;
    wr(16'h1000, 8'h00);
    chk(r, epc_pkg::RESP_SLVERR);
    rc(16'h1000, 8'h00);
    chk(r, epc_pkg::RESP_SLVERR);
    $display("reset and refusal test done");
    wr(16'h0, 8'h04);
    wr(16'h0, 8'h00);
    rc(16'h0, 8'h04);
    op(2'b00, ca(127), 8'ha5, 1'b1);
    op(2'b00, ca(127), 8'h3c, 1'b1);
    rc(ca(127), 8'h24);
    op(2'b00, ca(128), 8'h0f, 1'b1);
    op(2'b01, ca(128), 8'h00, 1'b1);
    rc(ca(128), 8'hff);
    $display("program and byte erase test done");
    op(2'b00, ca(255), 8'h00, 1'b1);
    op(2'b10, ca(200), 8'h5a, 1'b1);
    rc(ca(255), 8'hff);
    rc(ca(127), 8'h24);
    op(2'b11, ca(300), 8'h00, 1'b1);
    rc(ca(127), 8'hff);
    rc(16'h0004, 8'h10);
    $display("block and bulk erase test done");
    op(2'b01, 16'h0004, 8'h00, 1'b1);
    op(2'b00, 16'h0004, 8'h11, 1'b1);
    rc(16'h0008, 8'h10);
    rc(16'h0004, 8'h11);
    rc(16'h0008, 8'h11);
    op(2'b00, ca(10), 8'h00, 1'b0);
    rc(ca(10), 8'hff);
    op(2'b00, ca(300), 8'h0f, 1'b1);
    op(2'b11, ca(300), 8'h00, 1'b0);
    op(2'b10, ca(5), 8'h00, 1'b0);
    rc(ca(300), 8'h0f);
    $display("protection test done");
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule // tb
`default_nettype wire
